/* File: src/lanka_supervisor.sv */
// Link keepalive supervisor: idle timing, probing, fallback to local
// Notes on behaviour
// - Enable setting, on after reset
// - While enabled, check link at timeout intervals
// - Timeout seconds, 2 to 300, reset 45
// - Probing starts after idle exceeds timeout
// - Probe count times, 2 to 10, reset 2
// - Failed probes force local front-panel control
// - Enable, timeout, probe count read back
`timescale 1ns/1ps
`include "lanka_regs.svh"
module lanka_supervisor
	import lanka_pkg::*;
(
	input wire logic core_clk, // 125 MHz clock
	input wire logic rst, // Synchronous reset, active high
	input wire logic sec_tick, // One-cycle seconds tick, same domain
	input wire logic link_activity, // Valid traffic seen, pin level
	input wire logic probe_reply, // Probe answered, pin level
	input wire logic enable_wr, // Write strobe for enable
	input wire logic enable_wdata, // Enable value to write
	input wire logic timeout_wr, // Write strobe for timeout
	input wire logic [8:0] timeout_wdata, // Timeout seconds to write
	input wire logic probes_wr, // Write strobe for probe count
	input wire logic [3:0] probes_wdata, // Probe count to write
	input wire logic remote_active, // Remote control claimed by host
	output logic supervision_enable, // Present enable
	output logic [8:0] idle_timeout_seconds, // Present timeout
	output logic [3:0] probe_count, // Present probe count
	output logic probe_req, // One-cycle probe send pulse
	output logic go_local, // One-cycle fallback pulse
	output logic remote_mode, // High while in remote control
	output logic setting_error // Pulse on rejected write
);
	lanka_state_t state_reg, state_next;
	logic [8:0] idle_sec_reg;
	logic [3:0] sent_reg;
	logic [8:0] wait_sec_reg;
	logic act_s, reply_s, act_d_reg, reply_d_reg;
	logic act_pulse, reply_pulse, traffic;
	logic timeout_ok, probes_ok, idle_expired, wait_expired, probes_done;
	logic remote_reg;

	// Both pins cross into core_clk here; nothing reads them raw
	lanka_sync #(.W(2)) lanka_sync_inst (
		.core_clk(core_clk),
		.rst(rst),
		.d({link_activity, probe_reply}),
		.q({act_s, reply_s})
	);

	// Detectors reset low, the idle pin level, so no false event after reset
	assign act_pulse = act_s & ~act_d_reg;
	assign reply_pulse = reply_s & ~reply_d_reg;
	assign traffic = act_pulse | reply_pulse;
	assign timeout_ok = (timeout_wdata >= `LANKA_TIMEOUT_MIN)
		&& (timeout_wdata <= `LANKA_TIMEOUT_MAX);
	assign probes_ok = (probes_wdata >= `LANKA_PROBES_MIN)
		&& (probes_wdata <= `LANKA_PROBES_MAX);
	// Strictly longer than the timeout, so one tick past it
	assign idle_expired = sec_tick && (idle_sec_reg >= idle_timeout_seconds);
	assign wait_expired = sec_tick && (wait_sec_reg >= `LANKA_PROBE_WAIT_S);
	assign probes_done = (sent_reg >= probe_count);
	assign probe_req = (state_reg == LANKA_PROBE);
	assign go_local = (state_reg == LANKA_FAIL);
	assign remote_mode = remote_reg;

	// Out-of-range writes dropped and flagged, never clamped
	always_ff @(posedge core_clk) begin
		if (rst) begin
			supervision_enable <= `LANKA_ENABLE_RST;
			idle_timeout_seconds <= `LANKA_TIMEOUT_RST;
			probe_count <= `LANKA_PROBES_RST;
			setting_error <= 1'b0;
		end else begin
			setting_error <= (timeout_wr & ~timeout_ok) | (probes_wr & ~probes_ok);
			if (enable_wr) begin
				supervision_enable <= enable_wdata;
			end
			if (timeout_wr && timeout_ok) begin
				idle_timeout_seconds <= timeout_wdata;
			end
			if (probes_wr && probes_ok) begin
				probe_count <= probes_wdata;
			end
		end
	end

	// Disable overrides every state, so no probe leaves from the second cycle off on
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			LANKA_IDLE: begin
				if (idle_expired && !traffic) begin
					state_next = LANKA_PROBE;
				end
			end
			LANKA_PROBE: begin
				state_next = traffic ? LANKA_IDLE : LANKA_WAIT;
			end
			LANKA_WAIT: begin
				if (traffic) begin
					state_next = LANKA_IDLE;
				end else if (wait_expired) begin
					state_next = probes_done ? LANKA_FAIL : LANKA_PROBE;
				end
			end
			LANKA_FAIL: begin
				state_next = LANKA_IDLE;
			end
			default: begin
				state_next = LANKA_IDLE;
			end
		endcase
		if (!supervision_enable) begin
			state_next = LANKA_IDLE;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			state_reg <= LANKA_IDLE;
			act_d_reg <= 1'b0;
			reply_d_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			act_d_reg <= act_s;
			reply_d_reg <= reply_s;
		end
	end

	// Idle seconds count only in idle; traffic clears it
	always_ff @(posedge core_clk) begin
		if (rst || traffic || state_reg != LANKA_IDLE) begin
			idle_sec_reg <= 9'h000;
		end else if (sec_tick && idle_sec_reg != 9'h1FF) begin
			idle_sec_reg <= idle_sec_reg + 9'h001;
		end
	end

	// Probe wait counts ticks from the probe; a reply must land inside it
	always_ff @(posedge core_clk) begin
		if (rst || state_reg == LANKA_IDLE) begin
			sent_reg <= 4'h0;
			wait_sec_reg <= 9'h000;
		end else if (state_reg == LANKA_PROBE) begin
			sent_reg <= sent_reg + 4'h1;
			wait_sec_reg <= 9'h000;
		end else if (sec_tick) begin
			wait_sec_reg <= wait_sec_reg + 9'h001;
		end
	end

	// Remote claim sets remote_reg, held until fallback; fallback wins over a claim in the same cycle
	always_ff @(posedge core_clk) begin
		if (rst) begin
			remote_reg <= 1'b0;
		end else if (state_reg == LANKA_FAIL) begin
			remote_reg <= 1'b0;
		end else if (remote_active) begin
			remote_reg <= 1'b1;
		end
	end


	// Checks sample the same edge as the registers they guard
	reset_vals_a: assert property (@(posedge core_clk) $fell(rst) |->
		supervision_enable == `LANKA_ENABLE_RST
		&& idle_timeout_seconds == `LANKA_TIMEOUT_RST && probe_count == `LANKA_PROBES_RST)
		else $error("reset values wrong");
	timeout_range_a: assert property (@(posedge core_clk) disable iff (rst)
		idle_timeout_seconds >= `LANKA_TIMEOUT_MIN && idle_timeout_seconds <= `LANKA_TIMEOUT_MAX)
		else $error("timeout out of range");
	probe_range_a: assert property (@(posedge core_clk) disable iff (rst)
		probe_count >= `LANKA_PROBES_MIN && probe_count <= `LANKA_PROBES_MAX)
		else $error("probe count out of range");
	no_probe_off_a: assert property (@(posedge core_clk) disable iff (rst)
		!supervision_enable |=> !probe_req)
		else $error("probe while disabled");
	early_probe_a: assert property (@(posedge core_clk) disable iff (rst)
		$rose(probe_req) && $past(state_reg) == LANKA_IDLE |->
		$past(idle_sec_reg) >= idle_timeout_seconds)
		else $error("probe before timeout");
	idle_probe_a: assert property (@(posedge core_clk) disable iff (rst)
		supervision_enable && state_reg == LANKA_IDLE && idle_expired && !traffic |=> probe_req)
		else $error("no probe after timeout");
	probe_repeat_a: assert property (@(posedge core_clk) disable iff (rst)
		$rose(probe_req) && $past(state_reg) == LANKA_WAIT |->
		$past(sent_reg) < $past(probe_count))
		else $error("probe beyond count");
	fail_count_a: assert property (@(posedge core_clk) disable iff (rst)
		go_local |-> sent_reg == probe_count)
		else $error("fallback with wrong probe count");
	local_after_a: assert property (@(posedge core_clk) disable iff (rst)
		go_local |=> !remote_mode)
		else $error("remote kept after fallback");
	remote_claim_a: assert property (@(posedge core_clk) disable iff (rst)
		remote_active && !go_local |=> remote_mode)
		else $error("remote claim lost");
	traffic_clr_a: assert property (@(posedge core_clk) disable iff (rst)
		traffic && state_reg != LANKA_FAIL |=> state_reg == LANKA_IDLE && idle_sec_reg == 9'h000)
		else $error("traffic did not restart idle");
	write_ok_a: assert property (@(posedge core_clk) disable iff (rst)
		timeout_wr && timeout_ok |=> idle_timeout_seconds == $past(timeout_wdata))
		else $error("timeout write lost");
	enable_wr_a: assert property (@(posedge core_clk) disable iff (rst)
		enable_wr |=> supervision_enable == $past(enable_wdata))
		else $error("enable write lost");
	probes_wr_a: assert property (@(posedge core_clk) disable iff (rst)
		probes_wr && probes_ok |=> probe_count == $past(probes_wdata))
		else $error("probe count write lost");
	timeout_keep_a: assert property (@(posedge core_clk) disable iff (rst)
		timeout_wr && !timeout_ok |=> setting_error && $stable(idle_timeout_seconds))
		else $error("bad timeout taken");
	probes_keep_a: assert property (@(posedge core_clk) disable iff (rst)
		probes_wr && !probes_ok |=> setting_error && $stable(probe_count))
		else $error("bad probe count taken");

	probe_seen_c: cover property (@(posedge core_clk) disable iff (rst) probe_req);
	disabled_tick_c: cover property (@(posedge core_clk) disable iff (rst)
		!supervision_enable && sec_tick);
	fallback_c: cover property (@(posedge core_clk) disable iff (rst) go_local);
	recover_c: cover property (@(posedge core_clk) disable iff (rst)
		state_reg == LANKA_WAIT && traffic);
	bad_write_c: cover property (@(posedge core_clk) disable iff (rst) setting_error);
endmodule

/* File: src/lanka_regs.svh */
// Constants for the link keepalive supervisor
`ifndef LANKA_REGS_SVH
`define LANKA_REGS_SVH
`define LANKA_ENABLE_RST 1'h1
`define LANKA_TIMEOUT_MIN 9'h002
`define LANKA_TIMEOUT_MAX 9'h12C
`define LANKA_TIMEOUT_RST 9'h02D
`define LANKA_PROBES_MIN 4'h2
`define LANKA_PROBES_MAX 4'hA
`define LANKA_PROBES_RST 4'h2
`define LANKA_PROBE_WAIT_S 9'h001
`endif

/* File: src/lanka_pkg.sv */
// Types for the link keepalive supervisor
package lanka_pkg;
	typedef enum logic [1:0] {
		LANKA_IDLE = 2'h0,
		LANKA_PROBE = 2'h1,
		LANKA_WAIT = 2'h3,
		LANKA_FAIL = 2'h2
	} lanka_state_t;
endpackage

/* File: src/lanka_sync.sv */
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module lanka_sync #(
	parameter int W = 1
) (
	input wire logic core_clk, // Clock
	input wire logic rst, // Synchronous reset
	input wire logic [W-1:0] d, // Asynchronous input
	output logic [W-1:0] q // Synchronised output
);
	logic [W-1:0] meta_reg;
	always_ff @(posedge core_clk) begin
		if (rst) begin
			meta_reg <= '0;
			q <= '0;
		end else begin
			meta_reg <= d;
			q <= meta_reg;
		end
	end
endmodule

/* File: dv/lanka_host_model.sv */
// Remote host model: sends traffic and answers probes on request
`timescale 1ns/1ps
module lanka_host_model (
	input wire logic core_clk, // Clock
	input wire logic probe_req, // Probe from the supervisor
	input wire logic answer, // Host answers probes while high
	input wire logic traffic, // Strobe: send one traffic burst
	output logic link_activity, // Traffic pin
	output logic probe_reply // Reply pin
);
	logic [2:0] rcnt_reg = 3'h0;
	logic [2:0] tcnt_reg = 3'h0;
	// Pins held 4 cycles so the 2-flop sync never misses them
	always @(posedge core_clk) begin
		rcnt_reg <= (probe_req && answer) ? 3'h4 : (rcnt_reg != 3'h0) ? rcnt_reg - 3'h1 : 3'h0;
		tcnt_reg <= traffic ? 3'h4 : (tcnt_reg != 3'h0) ? tcnt_reg - 3'h1 : 3'h0;
	end
	assign probe_reply = (rcnt_reg != 3'h0);
	assign link_activity = (tcnt_reg != 3'h0);
endmodule

/* File: dv/lanka_supervisor_tb.sv */
// Testbench for the link keepalive supervisor
`timescale 1ns/1ps
`include "lanka_regs.svh"
module lanka_supervisor_tb;
	logic core_clk;
	logic rst = 1'h1, sec_tick = 1'h0, enable_wr = 1'h0, enable_wdata = 1'h0;
	logic timeout_wr = 1'h0, probes_wr = 1'h0, remote_active = 1'h0;
	logic answer = 1'h0, traffic = 1'h0;
	logic [8:0] timeout_wdata = 9'h000;
	logic [3:0] probes_wdata = 4'h0;
	logic link_activity, probe_reply, supervision_enable, probe_req;
	logic go_local, remote_mode, setting_error;
	logic [8:0] idle_timeout_seconds;
	logic [3:0] probe_count;
	int miscompares = 0, n_checks = 0, cyc = 0, n_probe = 0, n_local = 0, n_err = 0;
	lanka_supervisor lanka_supervisor_inst (.core_clk(core_clk), .rst(rst), .sec_tick(sec_tick),
		.link_activity(link_activity), .probe_reply(probe_reply), .enable_wr(enable_wr),
		.enable_wdata(enable_wdata), .timeout_wr(timeout_wr), .timeout_wdata(timeout_wdata),
		.probes_wr(probes_wr), .probes_wdata(probes_wdata), .remote_active(remote_active),
		.supervision_enable(supervision_enable), .idle_timeout_seconds(idle_timeout_seconds),
		.probe_count(probe_count), .probe_req(probe_req), .go_local(go_local),
		.remote_mode(remote_mode), .setting_error(setting_error));
	lanka_host_model lanka_host_model_inst (.core_clk(core_clk), .probe_req(probe_req),
		.answer(answer), .traffic(traffic), .link_activity(link_activity),
		.probe_reply(probe_reply));
	initial begin
		core_clk = 1'h0;
		forever #4 core_clk = ~core_clk;
	end
	// Pulses are one cycle wide, so count them at every edge
	always @(posedge core_clk) begin
		cyc++;
		if (probe_req === 1'h1) n_probe++;
		if (go_local === 1'h1) n_local++;
		if (setting_error === 1'h1) n_err++;
		if (cyc == 5000) begin
			miscompares++;
			test_done();
		end
	end
	task automatic test_done();
		$display("checks %0d miscompares %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk(input logic [8:0] got, input logic [8:0] exp);
		n_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wchk(input logic [2:0] sel, input logic [8:0] v, input logic [8:0] exp);
		int e;
		e = n_err;
		@(negedge core_clk);
		{probes_wr, timeout_wr, enable_wr} = sel;
		{timeout_wdata, enable_wdata, probes_wdata} = {v, v[0], v[3:0]};
		@(negedge core_clk);
		{probes_wr, timeout_wr, enable_wr} = 3'h0;
		@(negedge core_clk);
		chk(sel[1] ? idle_timeout_seconds : sel[2] ? {5'h00, probe_count}
			: {8'h00, supervision_enable}, exp);
		chk(9'(n_err - e), {8'h00, v !== exp});
	endtask
	task automatic ticks(input int n);
		repeat (n) begin
			@(negedge core_clk) sec_tick = 1'h1;
			@(negedge core_clk) sec_tick = 1'h0;
			repeat (8) @(negedge core_clk);
		end
	endtask
	task automatic t_settings();
		chk({8'h00, supervision_enable}, {8'h00, `LANKA_ENABLE_RST});
		chk(idle_timeout_seconds, 9'h02D);
		chk({5'h00, probe_count}, 9'h002);
		wchk(3'h2, 9'h12C, 9'h12C);
		wchk(3'h2, 9'h12D, 9'h12C);
		wchk(3'h2, 9'h001, 9'h12C);
		wchk(3'h2, 9'h002, 9'h002);
		wchk(3'h4, 9'h00A, 9'h00A);
		wchk(3'h4, 9'h00B, 9'h00A);
		wchk(3'h4, 9'h001, 9'h00A);
		wchk(3'h4, 9'h002, 9'h002);
		wchk(3'h1, 9'h000, 9'h000);
		wchk(3'h1, 9'h001, 9'h001);
	endtask
	task automatic t_fallback();
		@(negedge core_clk) remote_active = 1'h1;
		@(negedge core_clk) remote_active = 1'h0;
		chk({8'h00, remote_mode}, 9'h001);
		n_probe = 0;
		ticks(2);
		@(negedge core_clk) traffic = 1'h1;
		@(negedge core_clk) traffic = 1'h0;
		repeat (8) @(negedge core_clk);
		ticks(2);
		chk(9'(n_probe), 9'h000);
		ticks(1);
		chk(9'(n_probe), 9'h001);
		ticks(2);
		chk(9'(n_probe), 9'h002);
		chk(9'(n_local), 9'h000);
		ticks(2);
		chk(9'(n_local), 9'h001);
		chk(9'(n_probe), 9'h002);
		chk({8'h00, remote_mode}, 9'h000);
	endtask
	task automatic t_reply_and_disable();
		answer = 1'h1;
		n_probe = 0;
		n_local = 0;
		ticks(7);
		chk(9'(n_probe), 9'h002);
		chk(9'(n_local), 9'h000);
		answer = 1'h0;
		wchk(3'h1, 9'h000, 9'h000);
		n_probe = 0;
		ticks(6);
		chk(9'(n_probe + n_local), 9'h000);
	endtask
	initial begin
		repeat (6) @(negedge core_clk);
		rst = 1'h0;
		t_settings();
		t_fallback();
		t_reply_and_disable();
		test_done();
	end
endmodule
